// *** shared/bje_defs.svh ***
// Offsets, field positions, reset values and cycle counts of the branch and jump unit
`ifndef BJE_DEFS_SVH
`define BJE_DEFS_SVH

`define BJE_OFF_CTRL      12'h000
`define BJE_OFF_STATUS    12'h004
`define BJE_OFF_PTR       12'h008
`define BJE_OFF_FLAGS     12'h00c

`define BJE_CTRL_NARROW   0
`define BJE_STAT_BUSY     0
`define BJE_STAT_TAKEN    1
`define BJE_STAT_ILLEGAL  2

`define BJE_FLAG_OF       11
`define BJE_FLAG_SF       7
`define BJE_FLAG_ZF       6
`define BJE_FLAGS_MASK    16'h0fd5
`define BJE_FLAGS_RST     16'h0000
`define BJE_IP_RST        16'h0000
`define BJE_CS_RST        16'h0000

`define BJE_OP_LESS       8'h7c
`define BJE_OP_LESS_EQ    8'h7e
`define BJE_OP_SHORT      8'heb
`define BJE_OP_NEAR       8'he9
`define BJE_OP_FAR        8'hea
`define BJE_OP_GROUP      8'hff
`define BJE_REG_NEAR_IND  3'h4
`define BJE_REG_FAR_IND   3'h5

// Clock counts: 13, 4, 14, 11, 17, 21, 26, 34, 1
`define BJE_CYC_COND_TAKEN 6'h0d
`define BJE_CYC_COND_FALL  6'h04
`define BJE_CYC_DIRECT     6'h0e
`define BJE_CYC_IND_REG    6'h0b
`define BJE_CYC_IND_MEM_W  6'h11
`define BJE_CYC_IND_MEM_N  6'h15
`define BJE_CYC_FAR_MEM_W  6'h1a
`define BJE_CYC_FAR_MEM_N  6'h22
`define BJE_CYC_ILLEGAL    6'h01

`endif

// *** shared/bje_pkg.sv ***
// Types shared by the branch and jump unit
package bje_pkg;

  typedef enum logic {BJE_IDLE, BJE_EXEC} bje_state_e;

  typedef enum logic [2:0] {
    BJE_F_COND,
    BJE_F_SHORT,
    BJE_F_NEAR,
    BJE_F_IND,
    BJE_F_FAR_DIR,
    BJE_F_FAR_IND,
    BJE_F_BAD
  } bje_form_e;

  typedef logic [5:0] bje_cyc_t;

endpackage

// *** src/bje_branch_jump_execution.sv ***
// Branch and unconditional jump execution unit with APB register access
//
// Contract
// RQ1 - 0x7C branches only when sign differs overflow
// RQ2 - Signed conditional branches take 13 or 4
// RQ3 - 0x7E branches on zero or sign/overflow mismatch
// RQ4 - Displacement byte sign-extended, added to next pointer
// RQ5 - Short reach is -128 to +127 bytes
// RQ6 - 0xEB short jump, relative, 14 clocks
// RQ7 - 0xE9 adds 16-bit displacement, 14 clocks
// RQ8 - 0xFF /4 loads offset; 11, 17/21
// RQ9 - 0xEA loads segment and pointer, 14 clocks
// RQ10 - 0xFF /5 loads far pointer; 26/34
// RQ11 - Near jumps leave code segment untouched
// RQ12 - No return information is saved anywhere
// RQ13 - Only far jumps change the code segment
// RQ14 - No form alters the condition flags
// RQ15 - Taken branch uses larger count, fall-through smaller
`include "bje_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module bje_branch_jump_execution (
  input  wire logic        clk_i,          // Core clock, 25 MHz
  input  wire logic        rst_b_i,        // Async reset, active low
  input  wire logic        ce_i,           // Clock enable, freezes all state
  input  wire logic        psel_i,         // APB select
  input  wire logic        penable_i,      // APB enable
  input  wire logic        pwrite_i,       // APB write
  input  wire logic [11:0] paddr_i,        // APB byte address
  input  wire logic [31:0] pwdata_i,       // APB write data
  output logic      [31:0] prdata_o,       // APB read data
  output logic             pready_o,       // APB ready
  output logic             pslverr_o,      // APB error
  input  wire logic        start_i,        // Instruction present
  input  wire logic [7:0]  opcode_i,       // Opcode byte
  input  wire logic [2:0]  modrm_reg_i,    // Reg field of ModR/M
  input  wire logic        mem_operand_i,  // Operand came from memory
  input  wire logic [31:0] operand_i,      // Displacement, offset or seg:off
  input  wire logic [15:0] next_ip_i,      // Pointer of following instruction
  output logic             busy_o,         // Executing
  output logic             done_o,         // Completion pulse
  output logic             taken_o,        // Last instruction transferred control
  output logic             illegal_o,      // Last opcode not handled here
  output logic      [15:0] ip_o,           // Instruction pointer
  output logic      [15:0] cs_o,           // Code segment
  output logic      [15:0] flags_o         // Condition flags
);

  bje_pkg::bje_state_e state_r;
  bje_pkg::bje_form_e  form;
  bje_pkg::bje_cyc_t   cyc, cnt_r;
  logic [15:0] ip_r, cs_r, flags_r;
  logic [15:0] tgt_ip, tgt_cs, disp8_ext;
  logic [15:0] tgt_ip_r, tgt_cs_r;
  logic        far_r;
  logic        taken_nxt;
  logic        taken_hold_r, illegal_hold_r;
  logic        cond_met;
  logic        narrow_r;
  logic        busy_r, done_r, taken_r, illegal_r;
  logic        start_acc, commit;
  logic        sf, of_bit, zf;
  logic [31:0] prdata_r, rd_mux;
  logic        pready_r, pslverr_r;
  logic        apb_set, apb_done, wr_ok, hit, state_reg;

  assign sf        = flags_r[`BJE_FLAG_SF];
  assign of_bit    = flags_r[`BJE_FLAG_OF];
  assign zf        = flags_r[`BJE_FLAG_ZF];
  assign start_acc = ce_i && start_i && (state_r == bje_pkg::BJE_IDLE);
  assign commit    = ce_i && (state_r == bje_pkg::BJE_EXEC) && (cnt_r == 6'h00);
  // Fills the upper byte with the sign, giving reach -128..+127
  assign disp8_ext = {{8{operand_i[7]}}, operand_i[7:0]}; // RQ4 RQ5

  // Decode and condition evaluation
  always_comb
  begin
    form     = bje_pkg::BJE_F_BAD;
    cond_met = 1'b0;
    unique case (opcode_i)
      `BJE_OP_LESS:
      begin
        form     = bje_pkg::BJE_F_COND;
        cond_met = sf ^ of_bit; // RQ1
      end
      `BJE_OP_LESS_EQ:
      begin
        form     = bje_pkg::BJE_F_COND;
        cond_met = zf | (sf ^ of_bit); // RQ3
      end
      `BJE_OP_SHORT: form = bje_pkg::BJE_F_SHORT; // RQ6
      `BJE_OP_NEAR:  form = bje_pkg::BJE_F_NEAR; // RQ7
      `BJE_OP_FAR:   form = bje_pkg::BJE_F_FAR_DIR; // RQ9
      `BJE_OP_GROUP:
      begin
        if (modrm_reg_i == `BJE_REG_NEAR_IND)
          form = bje_pkg::BJE_F_IND; // RQ8
        else if (modrm_reg_i == `BJE_REG_FAR_IND && mem_operand_i)
          form = bje_pkg::BJE_F_FAR_IND; // RQ10
      end
      default: form = bje_pkg::BJE_F_BAD;
    endcase
  end

  assign taken_nxt = (form != bje_pkg::BJE_F_BAD) && ((form != bje_pkg::BJE_F_COND) || cond_met);

  // Cycle budget per form and variant
  always_comb
  begin
    cyc = `BJE_CYC_ILLEGAL;
    unique case (form)
      bje_pkg::BJE_F_COND:
        cyc = cond_met ? `BJE_CYC_COND_TAKEN : `BJE_CYC_COND_FALL; // RQ2 RQ15
      bje_pkg::BJE_F_SHORT,
      bje_pkg::BJE_F_NEAR,
      bje_pkg::BJE_F_FAR_DIR:
        cyc = `BJE_CYC_DIRECT; // RQ6 RQ7 RQ9
      bje_pkg::BJE_F_IND:
        if (!mem_operand_i)
          cyc = `BJE_CYC_IND_REG; // RQ8
        else
          cyc = narrow_r ? `BJE_CYC_IND_MEM_N : `BJE_CYC_IND_MEM_W; // RQ8
      bje_pkg::BJE_F_FAR_IND:
        cyc = narrow_r ? `BJE_CYC_FAR_MEM_N : `BJE_CYC_FAR_MEM_W; // RQ10
      bje_pkg::BJE_F_BAD:
        cyc = `BJE_CYC_ILLEGAL;
    endcase
  end

  // Target formation; nothing is pushed, so no return state exists
  always_comb
  begin
    tgt_ip = next_ip_i;
    tgt_cs = cs_r; // RQ11 RQ13
    unique case (form)
      bje_pkg::BJE_F_COND,
      bje_pkg::BJE_F_SHORT:
        if (taken_nxt)
          tgt_ip = next_ip_i + disp8_ext; // RQ4
      bje_pkg::BJE_F_NEAR:
        tgt_ip = next_ip_i + operand_i[15:0]; // RQ7
      bje_pkg::BJE_F_IND:
        tgt_ip = operand_i[15:0]; // RQ8
      bje_pkg::BJE_F_FAR_DIR,
      bje_pkg::BJE_F_FAR_IND:
      begin
        tgt_ip = operand_i[15:0]; // RQ9 RQ10
        tgt_cs = operand_i[31:16]; // RQ9 RQ10
      end
      bje_pkg::BJE_F_BAD:
        tgt_ip = ip_r;
    endcase
  end

  // Sequencer
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_r <= bje_pkg::BJE_IDLE;
      cnt_r   <= 6'h00;
      busy_r  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (start_acc)
      begin
        state_r <= bje_pkg::BJE_EXEC;
        cnt_r   <= cyc - 6'h01;
        busy_r  <= 1'b1;
      end
      else if (commit)
      begin
        state_r <= bje_pkg::BJE_IDLE;
        busy_r  <= 1'b0;
      end
      else if (state_r == bje_pkg::BJE_EXEC)
        cnt_r <= cnt_r - 6'h01;
    end
  end

  // Latched result of the decode
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tgt_ip_r       <= `BJE_IP_RST;
      tgt_cs_r       <= `BJE_CS_RST;
      far_r          <= 1'b0;
      taken_hold_r   <= 1'b0;
      illegal_hold_r <= 1'b0;
    end
    else if (start_acc)
    begin
      tgt_ip_r       <= tgt_ip;
      tgt_cs_r       <= tgt_cs;
      far_r          <= (form == bje_pkg::BJE_F_FAR_DIR) || (form == bje_pkg::BJE_F_FAR_IND); // RQ13
      taken_hold_r   <= taken_nxt;
      illegal_hold_r <= (form == bje_pkg::BJE_F_BAD);
    end
  end

  // Completion status
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      done_r    <= 1'b0;
      taken_r   <= 1'b0;
      illegal_r <= 1'b0;
    end
    else if (ce_i)
    begin
      done_r <= commit;
      if (commit)
      begin
        taken_r   <= taken_hold_r;
        illegal_r <= illegal_hold_r;
      end
    end
  end

  // Pointer and segment; bus writes are refused while busy so they never race a commit
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ip_r <= `BJE_IP_RST;
      cs_r <= `BJE_CS_RST;
    end
    else if (wr_ok && paddr_i == `BJE_OFF_PTR)
    begin
      ip_r <= pwdata_i[15:0];
      cs_r <= pwdata_i[31:16];
    end
    else if (commit)
    begin
      ip_r <= tgt_ip_r;
      if (far_r)
        cs_r <= tgt_cs_r; // RQ11 RQ13
    end
  end

  // Flags change only by software; no branch form writes them
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      flags_r <= `BJE_FLAGS_RST;
    else if (wr_ok && paddr_i == `BJE_OFF_FLAGS)
      flags_r <= pwdata_i[15:0] & `BJE_FLAGS_MASK; // RQ14
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      narrow_r <= 1'b0;
    else if (wr_ok && paddr_i == `BJE_OFF_CTRL)
      narrow_r <= pwdata_i[`BJE_CTRL_NARROW];
  end

  // APB slave: one wait state, answer computed at the setting edge
  assign apb_set   = ce_i && psel_i && penable_i && !pready_r;
  assign apb_done  = ce_i && psel_i && penable_i && pready_r;
  assign wr_ok     = apb_done && pwrite_i && !pslverr_r;
  assign state_reg = (paddr_i == `BJE_OFF_PTR) || (paddr_i == `BJE_OFF_FLAGS);
  assign hit       = (paddr_i == `BJE_OFF_CTRL) || (paddr_i == `BJE_OFF_STATUS) || state_reg;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr_i)
      `BJE_OFF_CTRL:   rd_mux[`BJE_CTRL_NARROW] = narrow_r;
      `BJE_OFF_STATUS:
      begin
        rd_mux[`BJE_STAT_BUSY]    = busy_r;
        rd_mux[`BJE_STAT_TAKEN]   = taken_r;
        rd_mux[`BJE_STAT_ILLEGAL] = illegal_r;
      end
      `BJE_OFF_PTR:    rd_mux = {cs_r, ip_r};
      `BJE_OFF_FLAGS:  rd_mux[15:0] = flags_r;
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      pready_r <= apb_set;
      if (apb_set)
      begin
        pslverr_r <= !hit || (pwrite_i && state_reg && (busy_r || start_acc));
        prdata_r  <= pwrite_i ? 32'h0000_0000 : rd_mux;
      end
      else if (apb_done)
      begin
        pslverr_r <= 1'b0;
        prdata_r  <= 32'h0000_0000;
      end
    end
  end

  assign prdata_o  = prdata_r;
  assign pready_o  = pready_r;
  assign pslverr_o = pslverr_r;
  assign busy_o    = busy_r;
  assign done_o    = done_r;
  assign taken_o   = taken_r;
  assign illegal_o = illegal_r;
  assign ip_o      = ip_r;
  assign cs_o      = cs_r;
  assign flags_o   = flags_r;

  AST_LESS_COND: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ1
    (start_acc && opcode_i == `BJE_OP_LESS) |=> (taken_hold_r == ($past(sf) ^ $past(of_bit))))
    else $error("Signed-less branch decision wrong");

  AST_LESS_EQ_COND: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ3
    (start_acc && opcode_i == `BJE_OP_LESS_EQ)
      |=> (taken_hold_r == ($past(zf) | ($past(sf) ^ $past(of_bit)))))
    else $error("Signed-less-or-equal branch decision wrong");

  AST_COND_COUNT: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ2 RQ15
    (start_acc && form == bje_pkg::BJE_F_COND)
      |=> (cnt_r == (taken_hold_r ? 6'h0c : 6'h03)))
    else $error("Conditional branch cycle count wrong");

  AST_SHORT_TARGET: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ4 RQ5
    (start_acc && opcode_i == `BJE_OP_SHORT)
      |=> (tgt_ip_r == $past(next_ip_i) + {{8{$past(operand_i[7])}}, $past(operand_i[7:0])}))
    else $error("Short target not sign-extended sum");

  AST_DIRECT_COUNT: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ6 RQ7 RQ9
    (start_acc && (opcode_i == `BJE_OP_SHORT || opcode_i == `BJE_OP_NEAR
      || opcode_i == `BJE_OP_FAR)) |=> (cnt_r == 6'h0d))
    else $error("Direct jump not 14 cycles");

  AST_NEAR_IND_COUNT: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ8
    (start_acc && form == bje_pkg::BJE_F_IND)
      |=> (cnt_r == (!$past(mem_operand_i) ? 6'h0a : ($past(narrow_r) ? 6'h14 : 6'h10))))
    else $error("Near indirect cycle count wrong");

  AST_FAR_IND_COUNT: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ10
    (start_acc && form == bje_pkg::BJE_F_FAR_IND)
      |=> (cnt_r == ($past(narrow_r) ? 6'h21 : 6'h19)))
    else $error("Far indirect cycle count wrong");

  AST_CS_NEAR_KEPT: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ11 RQ13
    (commit && !far_r) |=> $stable(cs_r))
    else $error("Code segment changed by non-far form");

  AST_FAR_LOAD: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ9 RQ10
    (commit && far_r) |=> (cs_r == $past(tgt_cs_r) && ip_r == $past(tgt_ip_r) && done_o))
    else $error("Far jump did not load segment and pointer");

  AST_FLAGS_KEPT: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ14
    (busy_r && $past(busy_r)) |-> $stable(flags_r))
    else $error("Flags changed during execution");

endmodule

`default_nettype wire

// *** bench/test_bje_branch_jump_execution.sv ***
// Self-checking bench for the branch and jump unit
`include "bje_defs.svh"
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end

module test_bje_branch_jump_execution;
  typedef struct {logic [15:0] ip; logic [15:0] cs; logic [15:0] fl;
                  logic tk; logic il; int cyc;} bje_note_s;
  logic        clk_i;
  logic        rst_b_i;
  logic        ce_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        start_i;
  logic [7:0]  opcode_i;
  logic [2:0]  modrm_reg_i;
  logic        mem_operand_i;
  logic [31:0] operand_i;
  logic [15:0] next_ip_i;
  logic        busy_o;
  logic        done_o;
  logic        taken_o;
  logic        illegal_o;
  logic [15:0] ip_o;
  logic [15:0] cs_o;
  logic [15:0] flags_o;
  int          n_fail;
  int          tests_run;
  int          cyc_n;
  int          t0;
  int          k;
  bje_note_s   iq[$];
  bje_note_s   nt;
  logic [32:0] aq[$];
  logic [32:0] an;
  logic [15:0] cur_ip;
  logic [15:0] cur_cs;
  logic [15:0] cur_fl;
  logic [15:0] nip;
  logic [15:0] w16;
  logic [31:0] w32;
  logic [7:0]  d8;
  logic        tk;

  bje_branch_jump_execution DUT (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .start_i(start_i), .opcode_i(opcode_i),
    .modrm_reg_i(modrm_reg_i), .mem_operand_i(mem_operand_i),
    .operand_i(operand_i), .next_ip_i(next_ip_i), .busy_o(busy_o),
    .done_o(done_o), .taken_o(taken_o), .illegal_o(illegal_o), .ip_o(ip_o),
    .cs_o(cs_o), .flags_o(flags_o));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [15:0] sx(input logic [7:0] d);
    return {{8{d[7]}}, d};
  endfunction

  task close_out;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee);
    int i;
    aq.push_back({ee, ed});
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_i);
      if (pready_o === 1'b1)
        break;
    end
    if (i == 20)
    begin
      n_fail++;
      close_out();
    end
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic ex(input logic [7:0] op, input logic [2:0] rg, input logic mm,
                    input logic [31:0] opd, input logic [15:0] eip,
                    input logic [15:0] ecs, input logic etk, input logic il,
                    input int cyc);
    int i;
    iq.push_back('{eip, ecs, cur_fl, etk, il, cyc});
    start_i       <= 1'b1;
    opcode_i      <= op;
    modrm_reg_i   <= rg;
    mem_operand_i <= mm;
    operand_i     <= opd;
    next_ip_i     <= nip;
    @(posedge clk_i);
    start_i <= 1'b0;
    for (i = 0; i < 60; i++)
    begin
      @(posedge clk_i);
      if (done_o === 1'b1)
        break;
    end
    if (i == 60)
    begin
      n_fail++;
      close_out();
    end
    cur_ip = eip;
    cur_cs = ecs;
  endtask

  // Results are judged where they appear, against the oldest note
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (start_i === 1'b1 && busy_o === 1'b0)
      t0 = cyc_n;
    if (iq.size() > 0 && cyc_n == t0 + 1)
      `CHK(busy_o, 1'b1)
    if (done_o === 1'b1 && iq.size() > 0)
    begin
      nt = iq.pop_front();
      `CHK(busy_o, 1'b0)
      `CHK(ip_o, nt.ip)
      `CHK(cs_o, nt.cs)
      `CHK(flags_o, nt.fl)
      `CHK(taken_o, nt.tk)
      `CHK(illegal_o, nt.il)
      `CHK(cyc_n - t0, nt.cyc + 1)
    end
    if (pready_o === 1'b1 && aq.size() > 0)
    begin
      an = aq.pop_front();
      `CHK(pslverr_o, an[32])
      // Read data only matters on a clean read
      if (pwrite_i === 1'b0 && an[32] === 1'b0)
        `CHK(prdata_o, an[31:0])
    end
  end

  initial
  begin
    {rst_b_i, psel_i, penable_i, pwrite_i, start_i, mem_operand_i} = '0;
    {paddr_i, pwdata_i, opcode_i, modrm_reg_i, operand_i, next_ip_i} = '0;
    ce_i = 1'b1;
    {n_fail, tests_run, cyc_n, t0} = '0;
    {cur_ip, cur_cs, cur_fl} = '0;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    w32 = $urandom(6);
    `CHK({ip_o, cs_o, flags_o}, 48'h0)
    apb(0, `BJE_OFF_CTRL, 0, 32'h0, 0);
    apb(0, `BJE_OFF_PTR, 0, 32'h0, 0);
    apb(0, 12'h010, 0, 32'h0, 1);
    apb(1, `BJE_OFF_STATUS, 32'hffffffff, 0, 0);
    apb(0, `BJE_OFF_STATUS, 0, 32'h0, 0);
    apb(1, `BJE_OFF_FLAGS, 32'hffffffff, 0, 0);
    apb(0, `BJE_OFF_FLAGS, 0, {16'h0, `BJE_FLAGS_MASK}, 0);
    cur_fl = `BJE_FLAGS_MASK;
    w32 = $urandom();
    nip = 16'($urandom());
    ex(`BJE_OP_FAR, 0, 0, w32, w32[15:0], w32[31:16], 1, 0, 14);
    apb(0, `BJE_OFF_PTR, 0, w32, 0);
    apb(0, `BJE_OFF_STATUS, 0, 32'h2, 0);
    // Every sign, overflow and zero combination on both conditions
    for (k = 0; k < 16; k++)
    begin
      w16 = 16'($urandom()) & `BJE_FLAGS_MASK;
      w16[`BJE_FLAG_SF] = k[0];
      w16[`BJE_FLAG_OF] = k[1];
      w16[`BJE_FLAG_ZF] = k[2];
      apb(1, `BJE_OFF_FLAGS, {16'h0, w16}, 0, 0);
      cur_fl = w16;
      d8 = 8'($urandom());
      nip = 16'($urandom());
      tk = (k[0] ^ k[1]) | (k[3] & k[2]);
      ex(k[3] ? `BJE_OP_LESS_EQ : `BJE_OP_LESS, 0, 0, {24'h0, d8},
         tk ? nip + sx(d8) : nip, cur_cs, tk, 0, tk ? 13 : 4);
    end
    // Both ends of the short reach
    nip = 16'h1000;
    for (k = 0; k < 4; k++)
    begin
      d8 = (k == 0) ? 8'h80 : (k == 1) ? 8'h7f : (k == 2) ? 8'h00 : 8'hff;
      ex(`BJE_OP_SHORT, 0, 0, {24'h0, d8}, nip + sx(d8), cur_cs, 1, 0, 14);
    end
    // Clock enable low for five edges stretches the jump by five
    d8 = 8'($urandom());
    fork
      ex(`BJE_OP_SHORT, 0, 0, {24'h0, d8}, nip + sx(d8), cur_cs, 1, 0, 19);
      begin
        repeat (4) @(posedge clk_i);
        ce_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        ce_i <= 1'b1;
      end
    join
    w16 = 16'($urandom());
    nip = 16'($urandom());
    fork
      ex(`BJE_OP_NEAR, 0, 0, {16'h0, w16}, nip + w16, cur_cs, 1, 0, 14);
      begin
        repeat (3) @(posedge clk_i);
        apb(1, `BJE_OFF_PTR, 32'h12345678, 0, 1);
        apb(0, `BJE_OFF_STATUS, 0, 32'h3, 0);
      end
    join
    for (k = 0; k < 3; k++)
    begin
      apb(1, `BJE_OFF_CTRL, {31'h0, k == 2}, 0, 0);
      w16 = 16'($urandom());
      ex(`BJE_OP_GROUP, `BJE_REG_NEAR_IND, k > 0, {16'h0, w16}, w16, cur_cs, 1, 0,
         (k == 0) ? 11 : (k == 1) ? 17 : 21);
    end
    for (k = 0; k < 2; k++)
    begin
      apb(1, `BJE_OFF_CTRL, {31'h0, k == 1}, 0, 0);
      w32 = $urandom();
      ex(`BJE_OP_GROUP, `BJE_REG_FAR_IND, 1, w32, w32[15:0], w32[31:16], 1, 0,
         k ? 34 : 26);
    end
    apb(0, `BJE_OFF_CTRL, 0, 32'h1, 0);
    ex(`BJE_OP_GROUP, `BJE_REG_FAR_IND, 0, $urandom(), cur_ip, cur_cs, 0, 1, 1);
    ex(`BJE_OP_GROUP, 3'h0, 1, $urandom(), cur_ip, cur_cs, 0, 1, 1);
    ex(8'h7d, 0, 0, $urandom(), cur_ip, cur_cs, 0, 1, 1);
    apb(0, `BJE_OFF_STATUS, 0, 32'h4, 0);
    repeat (3) @(posedge clk_i);
    close_out();
  end
endmodule

`default_nettype wire
